// ---- rtl/shcd_device.sv ----
// Device end: decodes host command bytes and holds the page-0 registers
// How it works
// - First byte's top two bits pick function
// - Address is six page bits, six register bits
// - Page select stores page for later accesses
// - Read takes in-page address from command
// - Read answers with three register bytes
// - Write command followed by three data bytes
// - Instruction aborts current process, starts new
// - Code bit five selects control or calibration
// - Fixed codes for reset, standby, conversions, halt
// - Calibration type and channels; AC offset current-only
// - Host watches status during continuous conversion
// - Checksum off at reset, enabled by bit
// - Checksum byte follows command and data
// - Checksum is 0xFF minus all bytes
// - Bad checksum: drop command, flag, restart receiver
// - Stalled transaction cleared after 128 ms
//
// Design decision made here: the byte link port to the host.
`timescale 1ns/1ps
module shcd_device #(
    parameter int TMO_CYCLES = shcd_pkg::TIMEOUT_CYCLES
) (
    input logic I_SYS_CLK,
    input logic I_RSTN,
    shcd_link_if.dev lnk,
    output logic [2:0] O_MODE,
    output logic O_INSTR_PULSE,
    output logic [5:0] O_INSTR_CODE,
    output logic [1:0] O_CAL_TYPE,
    output logic [2:0] O_CAL_CHAN,
    output logic O_SOFT_RESET,
    output logic O_IRQ
);
    typedef struct packed {
        shcd_pkg::shcd_dev_st_t st;
        logic [7:0] cmd;
        logic [23:0] data;
        logic [1:0] cnt;
        logic [7:0] sum;
        logic [5:0] page;
        shcd_pkg::shcd_regs_t regs;
        logic [23:0] status;
        logic [31:0] tmo;
        logic tx_v;
        logic [7:0] tx_b;
        shcd_pkg::shcd_mode_t mode;
        logic instr_p;
        logic [5:0] code;
        logic [1:0] cal_type;
        logic [2:0] cal_chan;
        logic srst_p;
        logic irq;
    } shcd_dev_t;

    localparam shcd_dev_t DEV_RST = '{
        st: shcd_pkg::D_IDLE,
        mode: shcd_pkg::MODE_IDLE,
        regs: shcd_pkg::reg_defaults(),
        default: '0
    };

    shcd_dev_t r_reg;
    shcd_dev_t r_next;
    logic go;
    logic cs_en;
    logic [7:0] rx_b;
    logic [5:0] addr;
    logic [3:0] slot;
    logic [23:0] set_b;
    logic [23:0] clr_b;

    always_comb begin
        r_next = r_reg;
        r_next.tx_v = 1'b0;
        r_next.instr_p = 1'b0;
        r_next.srst_p = 1'b0;
        go = 1'b0;
        set_b = 24'h000000;
        clr_b = 24'h000000;
        rx_b = lnk.h2d_byte;
        cs_en = r_reg.regs[shcd_pkg::SLOT_SLC]
            [shcd_pkg::SLC_CSUM_EN_BIT];
        addr = r_reg.cmd[5:0];
        slot = 4'h0;
        // Only a started, unfinished transaction can time out
        if (r_reg.st == shcd_pkg::D_DATA || r_reg.st == shcd_pkg::D_CSUM) begin
            r_next.tmo = r_reg.tmo + 32'h1;
        end else begin
            r_next.tmo = 32'h0;
        end
        case (r_reg.st)
            shcd_pkg::D_IDLE: begin
                if (lnk.h2d_valid) begin
                    r_next.cmd = rx_b;
                    r_next.sum = shcd_pkg::CSUM_SEED - rx_b;
                    r_next.cnt = 2'h0;
                    r_next.data = 24'h000000;
                    if (rx_b[7:6] == shcd_pkg::OP_WRITE) begin
                        r_next.st = shcd_pkg::D_DATA;
                    end else if (cs_en) begin
                        r_next.st = shcd_pkg::D_CSUM;
                    end else begin
                        go = 1'b1;
                    end
                end
            end
            shcd_pkg::D_DATA: begin
                if (lnk.h2d_valid) begin
                    r_next.tmo = 32'h0;
                    r_next.data = {r_reg.data[15:0], rx_b};
                    r_next.sum = r_reg.sum - rx_b;
                    r_next.cnt = r_reg.cnt + 2'h1;
                    if (r_reg.cnt == 2'(shcd_pkg::REG_BYTES - 1)) begin
                        if (cs_en) begin
                            r_next.st = shcd_pkg::D_CSUM;
                        end else begin
                            go = 1'b1;
                        end
                    end
                end
            end
            shcd_pkg::D_CSUM: begin
                if (lnk.h2d_valid) begin
                    r_next.tmo = 32'h0;
                    if (rx_b == r_reg.sum) begin
                        go = 1'b1;
                    end else begin
                        set_b[shcd_pkg::ST_CSUM_ERR_BIT] = 1'b1;
                        r_next.st = shcd_pkg::D_IDLE;
                    end
                end
            end
            shcd_pkg::D_SEND: begin
                // Host is expected to stay silent while the answer goes out
                r_next.tx_v = 1'b1;
                r_next.cnt = r_reg.cnt + 2'h1;
                if (r_reg.cnt == 2'(shcd_pkg::REG_BYTES)) begin
                    r_next.tx_b = r_reg.sum;
                end else begin
                    r_next.tx_b = r_reg.data[23:16];
                    r_next.data = {r_reg.data[15:0], 8'h00};
                    r_next.sum = r_reg.sum - r_reg.data[23:16];
                end
                if ((r_reg.cnt == 2'(shcd_pkg::REG_BYTES - 1) && !cs_en) ||
                    r_reg.cnt == 2'(shcd_pkg::REG_BYTES)) begin
                    r_next.st = shcd_pkg::D_IDLE;
                end
            end
            default: begin
                r_next.st = shcd_pkg::D_IDLE;
            end
        endcase
        if (r_next.tmo >= 32'(TMO_CYCLES)) begin
            r_next.st = shcd_pkg::D_IDLE;
            r_next.tmo = 32'h0;
            set_b[shcd_pkg::ST_TIMEOUT_BIT] = 1'b1;
        end
        if (go) begin
            r_next.st = shcd_pkg::D_IDLE;
            addr = r_next.cmd[5:0];
            slot = shcd_pkg::reg_slot(addr);
            case (r_next.cmd[7:6])
                shcd_pkg::OP_PAGE: begin
                    r_next.page = addr;
                end
                shcd_pkg::OP_READ: begin
                    r_next.st = shcd_pkg::D_SEND;
                    r_next.cnt = 2'h0;
                    r_next.sum = shcd_pkg::CSUM_SEED;
                    r_next.data = 24'h000000;
                    // Only page 0 is backed here; other pages read zero
                    if (r_reg.page == shcd_pkg::PAGE_HW) begin
                        if (slot[3]) begin
                            r_next.data = r_reg.regs[slot[2:0]];
                        end else if (addr == shcd_pkg::ADDR_STATUS) begin
                            r_next.data = r_reg.status;
                        end
                    end
                end
                shcd_pkg::OP_WRITE: begin
                    if (r_reg.page == shcd_pkg::PAGE_HW) begin
                        if (slot[3]) begin
                            r_next.regs[slot[2:0]] = r_next.data;
                        end
                        if (addr == shcd_pkg::ADDR_STATUS_CLR) begin
                            clr_b = r_next.data;
                        end
                    end
                end
                default: begin
                    r_next.instr_p = 1'b1;
                    r_next.code = addr;
                    if (addr[shcd_pkg::IC_CAL_BIT]) begin
                        r_next.mode = shcd_pkg::MODE_CAL;
                        r_next.cal_type = addr[4:3];
                        if (addr[4:3] == shcd_pkg::CAL_TYPE_AC_OFFSET) begin
                            r_next.cal_chan = addr[2:0] &
                                shcd_pkg::CAL_CHAN_CURRENT;
                        end else begin
                            r_next.cal_chan = addr[2:0];
                        end
                    end else begin
                        case (addr)
                            shcd_pkg::IC_SOFT_RESET: begin
                                r_next.regs = shcd_pkg::reg_defaults();
                                r_next.page = shcd_pkg::PAGE_HW;
                                r_next.status = 24'h000000;
                                r_next.mode = shcd_pkg::MODE_IDLE;
                                r_next.srst_p = 1'b1;
                            end
                            shcd_pkg::IC_STANDBY: begin
                                r_next.mode = shcd_pkg::MODE_STANDBY;
                            end
                            shcd_pkg::IC_SINGLE: begin
                                r_next.mode = shcd_pkg::MODE_SINGLE;
                            end
                            shcd_pkg::IC_CONT: begin
                                r_next.mode = shcd_pkg::MODE_CONT;
                            end
                            // Wakeup, halt and unknown codes all drop to idle
                            default: begin
                                r_next.mode = shcd_pkg::MODE_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
        // Set beats clear so no event is lost
        r_next.status = (r_next.status & ~clr_b) | set_b;
        r_next.irq = |(r_next.status & r_next.regs[shcd_pkg::SLOT_MASK]);
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            r_reg <= DEV_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign lnk.d2h_valid = r_reg.tx_v;
    assign lnk.d2h_byte = r_reg.tx_b;
    assign O_MODE = r_reg.mode;
    assign O_INSTR_PULSE = r_reg.instr_p;
    assign O_INSTR_CODE = r_reg.code;
    assign O_CAL_TYPE = r_reg.cal_type;
    assign O_CAL_CHAN = r_reg.cal_chan;
    assign O_SOFT_RESET = r_reg.srst_p;
    assign O_IRQ = r_reg.irq;
endmodule : shcd_device

// ---- rtl/shcd_host.sv ----
// Host end: APB-programmed controller that sends command transactions
`timescale 1ns/1ps
module shcd_host (
    input logic I_SYS_CLK,
    input logic I_RSTN,
    input logic I_PSEL,
    input logic I_PENABLE,
    input logic I_PWRITE,
    input logic [7:0] I_PADDR,
    input logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_IRQ,
    shcd_link_if.host lnk
);
    typedef struct packed {
        shcd_pkg::shcd_host_st_t st;
        logic [7:0] cmd;
        logic [23:0] wdata;
        logic [23:0] rdata;
        logic [2:0] cnt;
        logic [7:0] sum;
        logic cs_en;
        logic [1:0] irq_st;
        logic [1:0] irq_en;
        logic irq;
        logic tx_v;
        logic [7:0] tx_b;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } shcd_host_t;

    localparam shcd_host_t HOST_RST = '{st: shcd_pkg::H_IDLE, default: '0};

    shcd_host_t r_reg;
    shcd_host_t r_next;
    logic is_wr;
    logic is_rd;
    logic [2:0] last_tx;
    logic [1:0] set_b;
    logic [1:0] clr_b;
    logic [7:0] pa;

    always_comb begin
        r_next = r_reg;
        r_next.tx_v = 1'b0;
        set_b = 2'h0;
        clr_b = 2'h0;
        pa = I_PADDR;
        is_wr = (r_reg.cmd[7:6] == shcd_pkg::OP_WRITE);
        is_rd = (r_reg.cmd[7:6] == shcd_pkg::OP_READ);
        last_tx = (is_wr ? 3'(shcd_pkg::REG_BYTES) : 3'h0) +
                  (r_reg.cs_en ? 3'h1 : 3'h0);
        case (r_reg.st)
            shcd_pkg::H_SEND: begin
                // One byte per clock keeps far inside the inter-byte limit
                r_next.tx_v = 1'b1;
                r_next.cnt = r_reg.cnt + 3'h1;
                if (r_reg.cnt == 3'h0) begin
                    r_next.tx_b = r_reg.cmd;
                    r_next.sum = shcd_pkg::CSUM_SEED - r_reg.cmd;
                end else if (is_wr &&
                             r_reg.cnt <= 3'(shcd_pkg::REG_BYTES)) begin
                    r_next.tx_b = r_reg.wdata[23:16];
                    r_next.wdata = {r_reg.wdata[15:0], 8'h00};
                    r_next.sum = r_reg.sum - r_reg.wdata[23:16];
                end else begin
                    r_next.tx_b = r_reg.sum;
                end
                if (r_reg.cnt == last_tx) begin
                    r_next.cnt = 3'h0;
                    r_next.sum = shcd_pkg::CSUM_SEED;
                    if (is_rd) begin
                        r_next.st = shcd_pkg::H_WAIT;
                    end else begin
                        r_next.st = shcd_pkg::H_IDLE;
                        set_b[shcd_pkg::HIRQ_DONE] = 1'b1;
                    end
                end
            end
            shcd_pkg::H_WAIT: begin
                if (lnk.d2h_valid) begin
                    r_next.cnt = r_reg.cnt + 3'h1;
                    if (r_reg.cnt < 3'(shcd_pkg::REG_BYTES)) begin
                        r_next.rdata = {r_reg.rdata[15:0], lnk.d2h_byte};
                        r_next.sum = r_reg.sum - lnk.d2h_byte;
                    end else if (lnk.d2h_byte != r_reg.sum) begin
                        set_b[shcd_pkg::HIRQ_CSUM] = 1'b1;
                    end
                    if (r_reg.cnt == 3'(shcd_pkg::REG_BYTES) ||
                        (r_reg.cnt == 3'(shcd_pkg::REG_BYTES - 1) &&
                         !r_reg.cs_en)) begin
                        r_next.st = shcd_pkg::H_IDLE;
                        set_b[shcd_pkg::HIRQ_DONE] = 1'b1;
                    end
                end
            end
            default: begin
                r_next.st = shcd_pkg::H_IDLE;
            end
        endcase
        if (I_PSEL && I_PENABLE && !r_reg.pready) begin
            r_next.pready = 1'b1;
            r_next.pslverr = 1'b0;
            r_next.prdata = 32'h00000000;
            case (pa)
                shcd_pkg::HA_CTRL: r_next.prdata = {31'h0, r_reg.cs_en};
                shcd_pkg::HA_WDATA: r_next.prdata = {8'h00, r_reg.wdata};
                shcd_pkg::HA_RDATA: r_next.prdata = {8'h00, r_reg.rdata};
                shcd_pkg::HA_STAT: begin
                    r_next.prdata = {31'h0, r_reg.st != shcd_pkg::H_IDLE};
                end
                shcd_pkg::HA_IRQ_ST: r_next.prdata = {30'h0, r_reg.irq_st};
                shcd_pkg::HA_IRQ_EN: r_next.prdata = {30'h0, r_reg.irq_en};
                shcd_pkg::HA_CMD, shcd_pkg::HA_IRQ_CLR: begin
                    r_next.prdata = 32'h00000000;
                end
                default: r_next.pslverr = 1'b1;
            endcase
        end else if (I_PSEL && I_PENABLE && r_reg.pready) begin
            // Writes land on the completing edge only
            r_next.pready = 1'b0;
            r_next.pslverr = 1'b0;
            if (I_PWRITE) begin
                case (pa)
                    shcd_pkg::HA_CTRL: r_next.cs_en = I_PWDATA[0];
                    shcd_pkg::HA_WDATA: begin
                        if (r_reg.st == shcd_pkg::H_IDLE) begin
                            r_next.wdata = I_PWDATA[23:0];
                        end
                    end
                    shcd_pkg::HA_CMD: begin
                        // A busy controller ignores new commands
                        if (r_reg.st == shcd_pkg::H_IDLE) begin
                            r_next.cmd = I_PWDATA[7:0];
                            r_next.cnt = 3'h0;
                            r_next.st = shcd_pkg::H_SEND;
                        end
                    end
                    shcd_pkg::HA_IRQ_CLR: clr_b = I_PWDATA[1:0];
                    shcd_pkg::HA_IRQ_EN: r_next.irq_en = I_PWDATA[1:0];
                    default: r_next.pslverr = 1'b0;
                endcase
            end
        end else begin
            r_next.pready = 1'b0;
            r_next.pslverr = 1'b0;
        end
        r_next.irq_st = (r_reg.irq_st & ~clr_b) | set_b;
        r_next.irq = |(r_next.irq_st & r_next.irq_en);
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            r_reg <= HOST_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign lnk.h2d_valid = r_reg.tx_v;
    assign lnk.h2d_byte = r_reg.tx_b;
    assign O_PRDATA = r_reg.prdata;
    assign O_PREADY = r_reg.pready;
    assign O_PSLVERR = r_reg.pslverr;
    assign O_IRQ = r_reg.irq;
endmodule : shcd_host

// ---- rtl/shcd_link_if.sv ----
// Byte link between host controller end and device end
`timescale 1ns/1ps
interface shcd_link_if;
    logic h2d_valid;
    logic [7:0] h2d_byte;
    logic d2h_valid;
    logic [7:0] d2h_byte;
    modport dev(input h2d_valid, input h2d_byte,
                output d2h_valid, output d2h_byte);
    modport host(output h2d_valid, output h2d_byte,
                 input d2h_valid, input d2h_byte);
endinterface : shcd_link_if

// ---- rtl/shcd_pkg.sv ----
// Shared constants, types and helpers of the serial host command decoder
package shcd_pkg;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_PAGE = 2'h2;
    localparam logic [1:0] OP_INSTR = 2'h3;

    localparam int NREG = 7;
    localparam int REG_BYTES = 3;
    localparam logic [5:0] PAGE_HW = 6'h00;
    localparam logic [5:0] REG_ADDR [NREG] = '{6'h00, 6'h01, 6'h03, 6'h05,
                                              6'h07, 6'h08, 6'h09};
    localparam logic [23:0] REG_RST [NREG] = '{24'h400000, 24'h00EEEE,
        24'h000000, 24'h000000, 24'h02004D, 24'h000001, 24'h000000};
    localparam logic [2:0] SLOT_MASK = 3'h2;
    localparam logic [2:0] SLOT_SLC = 3'h4;
    localparam logic [5:0] ADDR_STATUS = 6'h17;
    localparam logic [5:0] ADDR_STATUS_CLR = 6'h1A;
    localparam int SLC_CSUM_EN_BIT = 18;
    localparam int ST_CSUM_ERR_BIT = 17;
    localparam int ST_TIMEOUT_BIT = 16;

    localparam logic [7:0] CSUM_SEED = 8'hFF;

    localparam logic [5:0] IC_SOFT_RESET = 6'h01;
    localparam logic [5:0] IC_STANDBY = 6'h02;
    localparam logic [5:0] IC_WAKEUP = 6'h03;
    localparam logic [5:0] IC_SINGLE = 6'h14;
    localparam logic [5:0] IC_CONT = 6'h15;
    localparam logic [5:0] IC_HALT = 6'h18;
    localparam int IC_CAL_BIT = 5;
    localparam logic [1:0] CAL_TYPE_AC_OFFSET = 2'h3;
    localparam logic [2:0] CAL_CHAN_CURRENT = 3'h5;

    localparam int TIMEOUT_MS = 128;
    localparam int CLK_HZ = 250000000;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);

    localparam logic [7:0] HA_CTRL = 8'h00;
    localparam logic [7:0] HA_CMD = 8'h04;
    localparam logic [7:0] HA_WDATA = 8'h08;
    localparam logic [7:0] HA_RDATA = 8'h0C;
    localparam logic [7:0] HA_STAT = 8'h10;
    localparam logic [7:0] HA_IRQ_ST = 8'h14;
    localparam logic [7:0] HA_IRQ_CLR = 8'h18;
    localparam logic [7:0] HA_IRQ_EN = 8'h1C;
    localparam int HIRQ_DONE = 0;
    localparam int HIRQ_CSUM = 1;

    typedef enum logic [1:0] {
        D_IDLE = 2'b00, D_DATA = 2'b01, D_CSUM = 2'b10, D_SEND = 2'b11
    } shcd_dev_st_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00, H_SEND = 2'b01, H_WAIT = 2'b10
    } shcd_host_st_t;
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000, MODE_STANDBY = 3'b001, MODE_SINGLE = 3'b010,
        MODE_CONT = 3'b011, MODE_CAL = 3'b100
    } shcd_mode_t;
    typedef logic [NREG-1:0][23:0] shcd_regs_t;

    // Returns {hit, slot} for an in-page address
    function automatic logic [3:0] reg_slot(input logic [5:0] a);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < NREG; i++) begin
            if (REG_ADDR[i] == a) begin
                s = {1'b1, 3'(i)};
            end
        end
        return s;
    endfunction : reg_slot

    function automatic shcd_regs_t reg_defaults();
        shcd_regs_t v;
        for (int i = 0; i < NREG; i++) begin
            v[i] = REG_RST[i];
        end
        return v;
    endfunction : reg_defaults
endpackage : shcd_pkg

// ---- verification/serial_host_command_decoder_bench.sv ----
// Self-checking bench for both decoder ends over the byte link
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module serial_host_command_decoder_bench;
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, serr, hirq, dirq;
    logic ipulse, srst;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] mode, cchan;
    logic [5:0] icode;
    logic [1:0] ctype;
    int n_mismatch = 0, total_checks = 0, n_pulse = 0, n_srst = 0;
    int mdl [int];
    int adr [8] = '{0, 1, 2, 3, 5, 7, 8, 9};
    logic [5:0] ic [8] = '{shcd_pkg::IC_STANDBY, shcd_pkg::IC_WAKEUP,
        shcd_pkg::IC_SINGLE, shcd_pkg::IC_CONT, shcd_pkg::IC_HALT,
        6'h25, 6'h3F, shcd_pkg::IC_SOFT_RESET};
    logic [2:0] em [8] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h0, 3'h4, 3'h4, 3'h0};
    shcd_link_if lnk ();
    shcd_host shcd_host_inst (.I_SYS_CLK(clk), .I_RSTN(rst_n),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_IRQ(hirq), .lnk(lnk));
    shcd_device #(.TMO_CYCLES(200)) shcd_device_inst (.I_SYS_CLK(clk),
        .I_RSTN(rst_n), .lnk(lnk), .O_MODE(mode), .O_INSTR_PULSE(ipulse),
        .O_INSTR_CODE(icode), .O_CAL_TYPE(ctype), .O_CAL_CHAN(cchan),
        .O_SOFT_RESET(srst), .O_IRQ(dirq));
    shcd_link_monitor shcd_link_monitor_inst (.I_SYS_CLK(clk),
        .I_RSTN(rst_n), .h2d_valid(lnk.h2d_valid), .h2d_byte(lnk.h2d_byte),
        .d2h_valid(lnk.d2h_valid), .d2h_byte(lnk.d2h_byte));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ipulse === 1'b1) n_pulse++;
        if (srst === 1'b1) n_srst++;
    end
    task close_out;
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task hang;
        n_mismatch++;
        close_out();
    endtask : hang
    // Each transfer opens on a fresh edge, so releases never collide
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        serr = pslverr;
        psel <= 0;
        pen <= 0;
        if (n >= 50) hang();
    endtask : apb
    task xact(input logic [7:0] c, input logic [23:0] d);
        int n;
        apb(1, shcd_pkg::HA_WDATA, {8'h00, d});
        apb(1, shcd_pkg::HA_CMD, {24'h000000, c});
        n = 0;
        do begin
            apb(0, shcd_pkg::HA_IRQ_ST, 32'h0);
            n++;
        end while (q[0] !== 1'b1 && n < 300);
        if (n >= 300) hang();
        `CHK("irq status", 32'h1, q)
        `CHK("host irq", 1'b1, hirq)
        apb(1, shcd_pkg::HA_IRQ_CLR, 32'h3);
    endtask : xact
    task wr(input logic [5:0] a, input logic [23:0] d);
        xact({shcd_pkg::OP_WRITE, a}, d);
        if (mdl.exists(a)) mdl[a] = d;
    endtask : wr
    task rd(input logic [5:0] a);
        xact({shcd_pkg::OP_READ, a}, 24'h000000);
        apb(0, shcd_pkg::HA_RDATA, 32'h0);
    endtask : rd
    task mreset;
        mdl[0] = 24'h400000;
        mdl[1] = 24'h00EEEE;
        mdl[3] = 24'h000000;
        mdl[5] = 24'h000000;
        mdl[7] = 24'h02004D;
        mdl[8] = 24'h000001;
        mdl[9] = 24'h000000;
    endtask : mreset
    task chk_all;
        int e;
        foreach (adr[i]) begin
            rd(6'(adr[i]));
            e = mdl.exists(adr[i]) ? mdl[adr[i]] : 0;
            `CHK("register", 32'(e), q)
        end
    endtask : chk_all
    initial begin
        int a;
        rst_n = 0;
        psel = 0;
        pen = 0;
        pwr = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(32'h233BB0BA));
        mreset();
        repeat (3) @(posedge clk);
        rst_n <= 1;
        apb(1, shcd_pkg::HA_IRQ_EN, 32'h1);
        apb(0, 8'h40, 32'h0);
        `CHK("slave error", 1'b1, serr)
        chk_all();
        repeat (10) begin
            a = adr[$urandom_range(7)];
            if (a != 7) wr(6'(a), 24'($urandom()));
        end
        chk_all();
        xact(8'h81, 24'h000000);
        xact({shcd_pkg::OP_WRITE, 6'h00}, 24'h123456);
        rd(6'h00);
        `CHK("other page", 32'h0, q)
        xact(8'h80, 24'h000000);
        chk_all();
        foreach (ic[i]) begin
            xact({shcd_pkg::OP_INSTR, ic[i]}, 24'h000000);
            `CHK("mode", em[i], mode)
            `CHK("code", ic[i], icode)
            if (i == 6) begin
                `CHK("cal type", 2'h3, ctype)
                `CHK("cal chan", 3'h5, cchan)
            end
        end
        `CHK("pulses", 8, n_pulse)
        `CHK("soft resets", 1, n_srst)
        mreset();
        chk_all();
        wr(6'h07, 24'h06004D);
        apb(1, shcd_pkg::HA_CTRL, 32'h1);
        wr(6'h05, 24'($urandom()));
        chk_all();
        // Host without checksum: second command lands as a bad checksum
        apb(1, shcd_pkg::HA_CTRL, 32'h0);
        xact({shcd_pkg::OP_WRITE, 6'h08}, 24'h000000);
        xact({shcd_pkg::OP_WRITE, 6'h08}, 24'h808080);
        repeat (250) @(posedge clk);
        apb(1, shcd_pkg::HA_CTRL, 32'h1);
        apb(0, shcd_pkg::HA_CTRL, 32'h0);
        `CHK("ctrl", 32'h1, q)
        rd(6'h17);
        `CHK("status", 32'h30000, q & 32'h30000)
        wr(6'h03, 24'h020000);
        `CHK("device irq", 1'b1, dirq)
        wr(6'h1A, 24'h030000);
        rd(6'h17);
        `CHK("status clear", 32'h0, q & 32'h30000)
        `CHK("device irq off", 1'b0, dirq)
        chk_all();
        `CHK("host irq off", 1'b0, hirq)
        close_out();
    end
endmodule : serial_host_command_decoder_bench

// ---- verification/shcd_link_monitor.sv ----
// Link checker between the two decoder ends
`timescale 1ns/1ps
module shcd_link_monitor (
    input logic I_SYS_CLK,
    input logic I_RSTN,
    input logic h2d_valid,
    input logic [7:0] h2d_byte,
    input logic d2h_valid,
    input logic [7:0] d2h_byte
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RSTN);
    a_read_gets_answer: assert property ($rose(h2d_valid)
        && h2d_byte[7:6] == shcd_pkg::OP_READ |-> ##[2:4] d2h_valid)
        else $error("read command got no answer");
    a_answer_min_len: assert property ($rose(d2h_valid)
        |-> d2h_valid[*3]) else $error("answer shorter than 3 bytes");
    a_answer_max_len: assert property (d2h_valid[*4]
        |=> !d2h_valid) else $error("answer longer than 4 bytes");
    a_answer_csum_ok: assert property (d2h_valid[*4]
        |-> d2h_byte == 8'(8'hFF - $past(d2h_byte, 1)
        - $past(d2h_byte, 2) - $past(d2h_byte, 3)))
        else $error("answer checksum wrong");
    a_write_data_follow: assert property ($rose(h2d_valid)
        && h2d_byte[7:6] == shcd_pkg::OP_WRITE |-> h2d_valid[*4])
        else $error("write not followed by 3 data bytes");
    a_write_csum_ok: assert property (h2d_valid[*5]
        |-> h2d_byte == 8'(8'hFF - $past(h2d_byte, 1) - $past(h2d_byte, 2)
        - $past(h2d_byte, 3) - $past(h2d_byte, 4)))
        else $error("write checksum wrong");
    a_link_one_way: assert property (d2h_valid |-> !h2d_valid)
        else $error("host byte during answer");
    a_instr_no_answer: assert property ($rose(h2d_valid)
        && h2d_byte[7:6] == shcd_pkg::OP_INSTR |-> (!d2h_valid)[*6])
        else $error("instruction answered");
    a_page_no_answer: assert property ($rose(h2d_valid)
        && h2d_byte[7:6] == shcd_pkg::OP_PAGE |-> (!d2h_valid)[*6])
        else $error("page select answered");
endmodule : shcd_link_monitor
